// [rtl/standby_ctrl.sv]
// Standby controller: halt and stop states with wake-up sequencing
//
// Behaviour
// - Halt gates CPU clock, oscillator keeps running
// - Stop halts main oscillator and system
// - Interrupt releases stop after oscillator stabilizes
// - Standby keeps registers, memory, ports unchanged
// - Reset from halt waits 2^15 clocks
// - Mask and enable decide halt wake action
`timescale 1ns/1ps
`include "standby_defs.svh"
module standby_ctrl
  import standby_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // CPU instruction strobes (same clock)
  input wire logic halt_exec_i,
  input wire logic stop_exec_i,
  // Interrupt requests (asynchronous pins)
  input wire logic mask_req_i,
  input wire logic nmi_req_i,
  // Interrupt state (same clock)
  input wire logic request_mask_flag_i,
  input wire logic global_irq_enable_i,
  // External reset request while halted (asynchronous pin)
  input wire logic reset_req_i,
  // Clock control outputs
  output logic cpu_clk_en_o,
  output logic osc_en_o,
  output logic hold_state_o,
  // Wake outcome towards the CPU
  output logic resume_next_o,
  output logic resume_vector_o,
  output logic reset_vector_o
);
  typedef struct packed {
    stby_state_t st;
    logic [15:0] cnt;
    logic mreq_pend;
    logic nmi_pend;
    logic mtgl_seen;
    logic ntgl_seen;
    logic cpu_clk_en;
    logic osc_en;
    logic hold;
    logic res_next;
    logic res_vec;
    logic res_rst;
  } regs_t;

  localparam logic [15:0] WAIT_LAST = 16'(`STBY_OSC_WAIT_CYC - 32'd1);

  regs_t q, d;
  logic mreq_s, nmi_s, rst_s;
  logic mtgl_q;
  logic ntgl_q;
  logic mtgl_s;
  logic ntgl_s;
  logic m_edge;
  logic n_edge;

  // Halt-state wake decision from mask and global enable
  function automatic wake_t wake_decide(input logic mreq, input logic nmi,
                                        input logic mk, input logic ie);
    if (nmi)
      wake_decide = WAKE_VECTOR;
    else if (mreq && !mk)
      wake_decide = ie ? WAKE_VECTOR : WAKE_NEXT;
    else
      wake_decide = WAKE_NONE;
  endfunction

  // Request catch that needs no main clock: each rising pin edge flips a toggle,
  // so a short pulse is remembered and a later stop is not woken by an old one
  always_ff @(posedge mask_req_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      mtgl_q <= 1'b0;
    else
      mtgl_q <= ~mtgl_q;
  end

  // Same catch for the non-maskable request
  always_ff @(posedge nmi_req_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ntgl_q <= 1'b0;
    else
      ntgl_q <= ~ntgl_q;
  end

  wake_sync u_sync_mreq (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(mask_req_i),
    .sync_o(mreq_s)
  );
  wake_sync u_sync_nmi (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(nmi_req_i),
    .sync_o(nmi_s)
  );
  wake_sync u_sync_rst (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(reset_req_i),
    .sync_o(rst_s)
  );

  wake_sync u_sync_mtgl (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(mtgl_q),
    .sync_o(mtgl_s)
  );
  wake_sync u_sync_ntgl (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(ntgl_q),
    .sync_o(ntgl_s)
  );

  // One-cycle marks of a new request edge seen by the toggles
  assign m_edge = mtgl_s ^ q.mtgl_seen;
  assign n_edge = ntgl_s ^ q.ntgl_seen;

  // Next-state logic
  always_comb
  begin
    wake_t w;
    w = wake_decide(mreq_s || q.mreq_pend, nmi_s || q.nmi_pend,
                    request_mask_flag_i, global_irq_enable_i);
    d = q;
    d.res_next = 1'b0;
    d.res_vec = 1'b0;
    d.res_rst = 1'b0;
    d.mtgl_seen = mtgl_s;
    d.ntgl_seen = ntgl_s;
    case (q.st)
      ST_RUN:
      begin
        d.cpu_clk_en = 1'b1;
        d.osc_en = 1'b1;
        d.hold = 1'b0;
        if (stop_exec_i)
        begin
          d.st = ST_STOP;
          d.cpu_clk_en = 1'b0;
          d.osc_en = 1'b0;
          d.hold = 1'b1;
        end
        else if (halt_exec_i)
        begin
          d.st = ST_HALT;
          d.cpu_clk_en = 1'b0;
          d.hold = 1'b1;
        end
      end
      ST_HALT:
      begin
        if (rst_s)
        begin
          d.st = ST_RESET_WAIT;
          d.cnt = 16'h0000;
        end
        else if (w == WAKE_NEXT)
        begin
          d.st = ST_RUN;
          d.cpu_clk_en = 1'b1;
          d.hold = 1'b0;
          d.res_next = 1'b1;
        end
        else if (w == WAKE_VECTOR)
        begin
          d.st = ST_RUN;
          d.cpu_clk_en = 1'b1;
          d.hold = 1'b0;
          d.res_vec = 1'b1;
        end
      end
      ST_STOP:
      begin
        if (m_edge || n_edge || mreq_s || nmi_s)
        begin
          d.st = ST_OSC_WAIT;
          d.osc_en = 1'b1;
          d.cnt = 16'h0000;
          // Remember the source so a pulse gone by the end of the wait still counts
          d.mreq_pend = m_edge || mreq_s;
          d.nmi_pend = n_edge || nmi_s;
        end
      end
      ST_OSC_WAIT:
      begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt == WAIT_LAST)
        begin
          // Same wake decision as in halt; masked request re-enters halt
          d.cpu_clk_en = (w != WAKE_NONE);
          d.hold = (w == WAKE_NONE);
          d.res_next = (w == WAKE_NEXT);
          d.res_vec = (w == WAKE_VECTOR);
          d.st = (w == WAKE_NONE) ? ST_HALT : ST_RUN;
          d.mreq_pend = 1'b0;
          d.nmi_pend = 1'b0;
        end
      end
      ST_RESET_WAIT:
      begin
        d.cnt = q.cnt + 16'h0001;
        if (q.cnt == WAIT_LAST)
        begin
          d.st = ST_RUN;
          d.cpu_clk_en = 1'b1;
          d.hold = 1'b0;
          d.res_rst = 1'b1;
        end
      end
      default:
      begin
        d.st = ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      q <= '0;
      q.st <= ST_RUN;
      q.cpu_clk_en <= 1'b1;
      q.osc_en <= 1'b1;
    end
    else
      q <= d;
  end

  // Outputs straight from flip-flops
  assign cpu_clk_en_o = q.cpu_clk_en;
  assign osc_en_o = q.osc_en;
  assign hold_state_o = q.hold;
  assign resume_next_o = q.res_next;
  assign resume_vector_o = q.res_vec;
  assign reset_vector_o = q.res_rst;

  a_halt_clock: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (q.st == ST_RUN && halt_exec_i && !stop_exec_i) |=> !cpu_clk_en_o && osc_en_o)
    else $error("halt did not gate cpu clock only");
  a_stop_osc: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (q.st == ST_RUN && stop_exec_i) |=> !osc_en_o && !cpu_clk_en_o)
    else $error("stop did not halt oscillator");
  a_stop_wait: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    $rose(osc_en_o) && q.st == ST_OSC_WAIT |-> !cpu_clk_en_o [*8])
    else $error("cpu resumed before oscillator settled");
  a_hold_state: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (q.st == ST_HALT || q.st == ST_STOP) |-> hold_state_o && !cpu_clk_en_o)
    else $error("state not held in standby");
  a_reset_wait: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    reset_vector_o |-> $past(q.st) == ST_RESET_WAIT && $past(q.cnt) == WAIT_LAST)
    else $error("reset vector before stabilization");
  a_masked_stays: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (q.st == ST_HALT && !rst_s && !nmi_s && request_mask_flag_i) |=> q.st == ST_HALT)
    else $error("masked request left halt");
  a_wake_next: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (q.st == ST_HALT && !rst_s && !nmi_s && mreq_s && !request_mask_flag_i
     && !global_irq_enable_i) |=> resume_next_o && cpu_clk_en_o)
    else $error("unmasked request with enable clear did not resume");
  a_stop_latch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    (q.st == ST_STOP && (m_edge || n_edge)) |=> q.st == ST_OSC_WAIT && osc_en_o)
    else $error("latched request did not restart oscillator");
  a_settle_off: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
    q.st == ST_OSC_WAIT |-> !cpu_clk_en_o && hold_state_o)
    else $error("cpu ran while oscillator settled");
endmodule // standby_ctrl

// [rtl/standby_defs.svh]
// Timing constants for the standby controller
`ifndef STANDBY_DEFS_SVH
`define STANDBY_DEFS_SVH
// Main clock period in picoseconds (40 MHz)
`define STBY_CLK_PERIOD_PS 25000
// Oscillator stabilization interval: 2^15 main clock periods
`define STBY_OSC_WAIT_LOG2 15
`define STBY_OSC_WAIT_CYC (32'd1 << `STBY_OSC_WAIT_LOG2)
`endif

// [rtl/standby_pkg.sv]
// Types for the standby controller
package standby_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_STOP,
    ST_OSC_WAIT,
    ST_RESET_WAIT
  } stby_state_t;
  typedef enum logic [1:0] {
    WAKE_NONE,
    WAKE_NEXT,
    WAKE_VECTOR
  } wake_t;
endpackage

// [rtl/wake_sync.sv]
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/1ps
module wake_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Level in and out
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q;
  // First stage feeds only the second
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // wake_sync

// [verification/cpu_model.sv]
// Behavioural CPU core that issues the standby instructions
`timescale 1ns/1ps
module cpu_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Instruction strobes
  output logic halt_exec_o,
  output logic stop_exec_o,
  // High while peripherals run
  output logic periph_run_o
);
  initial
  begin
    halt_exec_o = 1'b0;
    stop_exec_o = 1'b0;
    periph_run_o = 1'b1;
  end
  // One-cycle halt strobe
  task automatic exec_halt();
    wait (arst_n_i === 1'b1);
    @(posedge clk_sys_i);
    halt_exec_o <= 1'b1;
    @(posedge clk_sys_i);
    halt_exec_o <= 1'b0;
  endtask
  // Peripherals stop a cycle ahead of the stop strobe
  task automatic exec_stop();
    wait (arst_n_i === 1'b1);
    @(posedge clk_sys_i);
    periph_run_o <= 1'b0;
    @(posedge clk_sys_i);
    stop_exec_o <= 1'b1;
    @(posedge clk_sys_i);
    stop_exec_o <= 1'b0;
  endtask
endmodule // cpu_model

// [verification/test_standby_halt_stop_control.sv]
// Self-checking testbench for the standby controller
`timescale 1ns/1ps
`include "standby_defs.svh"
module test_standby_halt_stop_control;
  localparam int W = `STBY_OSC_WAIT_CYC;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic mask_req_i = 1'b0;
  logic nmi_req_i = 1'b0;
  logic request_mask_flag_i = 1'b0;
  logic global_irq_enable_i = 1'b0;
  logic reset_req_i = 1'b0;
  logic halt_exec_i, stop_exec_i, cpu_clk_en_o, osc_en_o, hold_state_o;
  logic resume_next_o, resume_vector_o, reset_vector_o;
  logic periph_run;
  int n_errors = 0;
  int n_compared = 0;
  // Clock at 40 MHz
  always #12.5 clk_sys_i = ~clk_sys_i;
  cpu_model i_cpu (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .halt_exec_o(halt_exec_i),
    .stop_exec_o(stop_exec_i), .periph_run_o(periph_run));
  standby_ctrl i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .halt_exec_i(halt_exec_i),
    .stop_exec_i(stop_exec_i), .mask_req_i(mask_req_i), .nmi_req_i(nmi_req_i),
    .request_mask_flag_i(request_mask_flag_i), .global_irq_enable_i(global_irq_enable_i),
    .reset_req_i(reset_req_i), .cpu_clk_en_o(cpu_clk_en_o), .osc_en_o(osc_en_o),
    .hold_state_o(hold_state_o), .resume_next_o(resume_next_o),
    .resume_vector_o(resume_vector_o), .reset_vector_o(reset_vector_o));
  // Compare one value
  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Wait for a wake pulse, bounded
  task automatic wait_wake(input int limit, output int n, output logic [2:0] seen);
    n = 0;
    seen = 3'b000;
    while (seen == 3'b000 && n < limit)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
      seen = {reset_vector_o, resume_vector_o, resume_next_o};
    end
  endtask
  // Enter standby and see the clocks and hold
  task automatic enter(input logic stop);
    if (stop)
      i_cpu.exec_stop();
    else
      i_cpu.exec_halt();
    @(posedge clk_sys_i);
    #1;
    check_val("cpu clock", 0, cpu_clk_en_o);
    check_val("oscillator", !stop, osc_en_o);
    check_val("hold", 1, hold_state_o);
    if (stop)
      check_val("peripherals stopped", 0, periph_run);
  endtask
  // Drop the requests and let the synchronisers settle
  task automatic release_all();
    @(posedge clk_sys_i);
    mask_req_i <= 1'b0;
    nmi_req_i <= 1'b0;
    reset_req_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask
  // Halt woken by a maskable or non-maskable request
  task automatic halt_case(input logic mk, input logic ie, input logic nmi, input logic [2:0] exp);
    int n;
    logic [2:0] seen;
    enter(1'b0);
    @(posedge clk_sys_i);
    request_mask_flag_i <= mk;
    global_irq_enable_i <= ie;
    mask_req_i <= 1'b1;
    nmi_req_i <= nmi;
    wait_wake(10, n, seen);
    check_val("halt wake", exp, seen);
    if (exp === 3'b000)
    begin
      check_val("still halted", 0, cpu_clk_en_o);
      @(posedge clk_sys_i);
      request_mask_flag_i <= 1'b0;
      wait_wake(10, n, seen);
      check_val("unmasked wake", 3'b010, seen);
    end
    check_val("clock back", 1, cpu_clk_en_o);
    check_val("hold off", 0, hold_state_o);
    release_all();
  endtask
  // Reset input releases halt after the long wait, ahead of an NMI
  task automatic halt_reset_case();
    int n;
    logic [2:0] seen;
    enter(1'b0);
    @(posedge clk_sys_i);
    reset_req_i <= 1'b1;
    nmi_req_i <= 1'b1;
    wait_wake(W + 20, n, seen);
    check_val("reset wake", 3'b100, seen);
    check_val("reset wait", 1, n >= W && n <= W + 4);
    release_all();
  endtask
  // Stop released by a request once the oscillator settles
  task automatic stop_case();
    int n;
    logic [2:0] seen;
    enter(1'b1);
    @(posedge clk_sys_i);
    request_mask_flag_i <= 1'b0;
    global_irq_enable_i <= 1'b1;
    mask_req_i <= 1'b1;
    n = 0;
    while (osc_en_o !== 1'b1 && n < 10)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check_val("osc restart", 1, osc_en_o);
    check_val("held while settling", 1, hold_state_o);
    wait_wake(W + 10, n, seen);
    check_val("stop wake", 3'b010, seen);
    check_val("stop wait", 1, n >= W - 1 && n <= W + 1);
    release_all();
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    check_val("reset state", 3'b110, {cpu_clk_en_o, osc_en_o, hold_state_o});
    halt_case(1'b0, 1'b0, 1'b0, 3'b001);
    halt_case(1'b0, 1'b1, 1'b0, 3'b010);
    halt_case(1'b1, 1'b1, 1'b0, 3'b000);
    halt_case(1'b1, 1'b0, 1'b1, 3'b010);
    halt_reset_case();
    stop_case();
    conclude();
  end
  // Watchdog
  initial
  begin
    #2000000;
    n_errors++;
    conclude();
  end
endmodule // test_standby_halt_stop_control
